// *** design/csr_pkg.sv ***
// Constants and carrier types for the clock generator page-zero register bank
package csr_pkg;

  // ****************************************
  // Register offsets within a page
  // ****************************************
  localparam logic [7:0] OFF_STEPPING = 8'h00;
  localparam logic [7:0] OFF_PAGE = 8'h01;
  localparam logic [7:0] OFF_DIGITS_LO = 8'h02;
  localparam logic [7:0] OFF_DIGITS_HI = 8'h03;
  localparam logic [7:0] OFF_SPEED = 8'h04;
  localparam logic [7:0] OFF_PRODREV = 8'h05;
  localparam logic [7:0] OFF_TEMP = 8'h09;
  localparam logic [7:0] OFF_PACKAGE = 8'h0A;
  localparam logic [7:0] OFF_SLAVE_ADDR = 8'h0B;
  localparam logic [7:0] OFF_LIVE = 8'h0C;
  localparam logic [7:0] OFF_LOST_LIVE = 8'h0D;
  localparam logic [7:0] OFF_STICKY = 8'h11;
  localparam logic [7:0] OFF_LOST_STICKY = 8'h12;
  localparam logic [7:0] OFF_MASKS = 8'h17;
  localparam logic [7:0] OFF_READY = 8'hFE;
  localparam logic [7:0] PAGE_ZERO = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CAL = 0;
  localparam int BIT_XTAL = 1;
  localparam int BIT_REF = 2;
  localparam int BIT_LOL = 3;
  localparam int BIT_TMO = 5;
  localparam logic [7:0] STATUS_IMPL = 8'h2F;
  localparam logic [7:0] LOST_IMPL = 8'h0F;
  localparam logic [7:0] SLAVE_ADDR_IMPL = 8'h7C;
  localparam int SLAVE_ADDR_LSB = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDR = 8'h00;
  localparam logic [7:0] RST_STICKY = 8'h00;
  localparam logic [7:0] RST_MASKS = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // One register access carried from the serial side to the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_req_t;

  localparam csr_req_t RST_REQ = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};

  // Live inputs from the analog side and the pins
  typedef struct packed {
    logic ready;
    logic [1:0] strap;
    logic [3:0] lost;
    logic tmo;
    logic pll_unlocked;
    logic ref_miss;
    logic xtal;
    logic cal;
  } csr_live_t;

  localparam csr_live_t RST_LIVE = '{default: 1'b0};

endpackage

// *** design/csr_regs.sv ***
// Page-zero status, identity and alarm register bank with serial-side crossing

// Notes on behaviour
// RQ1: Offset 0x01 on every page reads and writes the selected page.
// RQ2: Page selector is a full eight-bit read/write field.
// RQ3: Offset 0x00 low nibble is a fixed stepping code; writes ignored.
// RQ4: Base part digits as four BCD nibbles, low byte at 0x02, high 0x03.
// RQ5: Offset 0x04 returns a fixed eight-bit speed class code.
// RQ6: Offset 0x05 returns a fixed eight-bit product revision code.
// RQ7: Slave address bits 6:2 writable; bits 1:0 come from strap pins.
// RQ8: Live status bit 0 shows calibration in progress.
// RQ9: Live status bit 1 shows no signal on the crystal input.
// RQ10: Live status bit 2 shows no reference at the phase detector.
// RQ11: Live status bit 3 shows the synthesis loop out of lock.
// RQ12: Live status bit 5 shows a serial bus timeout.
// RQ13: Four live, non-latching input clock lost bits.
// RQ14: Lost bits map inputs zero, one, two, feedback to bits 0..3.
// RQ15: Each status bit has a sticky flag, cleared only by writing 0.
// RQ16: Each input lost sticky flag is cleared individually by writing 0.
// RQ17: Mask bits 0,1,2,3,5 at 0x17 stop matching flags raising interrupt.
// RQ18: Unmasked set flags drive the interrupt output; masked ones do not. Only the 0x11 status flags drive it here; lost flags at 0x12 never do.
// RQ19: Device ready readable at offset 0xFE on every page.
// RQ20: Writing 1 keeps a flag; a present condition sets it again.
// RQ21: Host clears flags by read-modify-write, writing 1 to keep others.
module csr_regs #(
  parameter logic [3:0] STEPPING_CODE = 4'h0, // arbitrary value
  parameter logic [15:0] BASE_DIGITS = 16'h1234, // arbitrary value
  parameter logic [7:0] SPEED_CODE = 8'h00, // arbitrary value
  parameter logic [7:0] PRODREV_CODE = 8'h00, // arbitrary value
  parameter logic [7:0] TEMP_CODE = 8'h00, // arbitrary value
  parameter logic [7:0] PACKAGE_CODE = 8'h00 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic link_clk_i,
  input wire logic link_req_i,
  input wire logic link_wr_i,
  input wire logic [7:0] link_addr_i,
  input wire logic [7:0] link_wdata_i,
  output logic link_busy_o,
  output logic link_done_o,
  output logic [7:0] link_rdata_o,
  input wire logic calibration_active_i,
  input wire logic crystal_signal_lost_i,
  input wire logic reference_missing_i,
  input wire logic pll_unlocked_i,
  input wire logic bus_timeout_i,
  input wire logic [3:0] input_clock_lost_i,
  input wire logic address_strap_high_i,
  input wire logic address_strap_low_i,
  input wire logic device_ready_i,
  output logic [6:0] slave_address_o,
  output logic irq_o
);

  // ****************************************
  // Serial side: request capture and answer
  // ****************************************
  csr_pkg::csr_req_t req;
  logic req_tgl;
  logic pend;
  logic done;
  logic [7:0] link_rdata;
  logic ack_s1;
  logic ack_s2;
  logic ack_s3;
  logic ack_tgl;
  logic [7:0] core_rdata;

  wire ack_evt = ack_s2 ^ ack_s3;
  wire take_req = link_req_i & ~pend;

  // Request held stable until the core answers, so the word crosses safely
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req <= csr_pkg::RST_REQ;
      req_tgl <= 1'b0;
      pend <= 1'b0;
    end else begin
      if (take_req) begin
        req <= '{wr: link_wr_i, addr: link_addr_i, wdata: link_wdata_i};
      end
      req_tgl <= req_tgl ^ take_req;
      pend <= take_req | (pend & ~ack_evt);
    end
  end

  // Answer toggle synchroniser; core read data is stable once ack flips
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      done <= 1'b0;
      link_rdata <= csr_pkg::RST_RDATA;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      done <= ack_evt;
      if (ack_evt) begin
        link_rdata <= core_rdata;
      end
    end
  end

  assign link_busy_o = pend;
  assign link_done_o = done;
  assign link_rdata_o = link_rdata;

  // ****************************************
  // Core side: synchronisers
  // ****************************************
  logic req_s1;
  logic req_s2;
  logic req_s3;
  csr_pkg::csr_live_t live_s1;
  csr_pkg::csr_live_t live;

  wire csr_pkg::csr_live_t live_pins = '{
    ready: device_ready_i,
    strap: {address_strap_high_i, address_strap_low_i},
    lost: input_clock_lost_i,
    tmo: bus_timeout_i,
    pll_unlocked: pll_unlocked_i,
    ref_miss: reference_missing_i,
    xtal: crystal_signal_lost_i,
    cal: calibration_active_i
  };

  // Pins are asynchronous to the core; two flops before any use
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      live_s1 <= csr_pkg::RST_LIVE;
      live <= csr_pkg::RST_LIVE;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      live_s1 <= live_pins;
      live <= live_s1;
    end
  end

  wire req_evt = req_s2 ^ req_s3;

  // ****************************************
  // Core side: decode
  // ****************************************
  logic [7:0] page;
  logic [4:0] addr_hi;
  logic [7:0] sticky;
  logic [7:0] lost_sticky;
  logic [7:0] masks;

  wire on_page0 = page == csr_pkg::PAGE_ZERO;
  wire do_wr = req_evt & req.wr;
  wire hit_page = req.addr == csr_pkg::OFF_PAGE; // RQ1
  wire hit_ready = req.addr == csr_pkg::OFF_READY; // RQ19
  wire hit_addr = on_page0 & (req.addr == csr_pkg::OFF_SLAVE_ADDR);
  wire hit_sticky = on_page0 & (req.addr == csr_pkg::OFF_STICKY);
  wire hit_lost = on_page0 & (req.addr == csr_pkg::OFF_LOST_STICKY);
  wire hit_masks = on_page0 & (req.addr == csr_pkg::OFF_MASKS);

  // Live status byte, bit 4 and bits 7:6 read as zero
  wire [7:0] live_status = {2'b00, live.tmo, 1'b0, live.pll_unlocked, live.ref_miss, live.xtal,
                            live.cal}; // RQ8 RQ9 RQ10 RQ11 RQ12
  wire [7:0] lost_live = {4'h0, live.lost}; // RQ13 RQ14

  // ****************************************
  // Core side: sticky flags and masks
  // ****************************************
  // A 0 written clears, a 1 keeps; the live condition always wins the cycle
  wire [7:0] clr_sticky = (do_wr & hit_sticky) ? ~req.wdata : 8'h00;
  wire [7:0] clr_lost = (do_wr & hit_lost) ? ~req.wdata : 8'h00;
  wire [7:0] next_sticky = ((sticky & ~clr_sticky) | live_status)
                           & csr_pkg::STATUS_IMPL; // RQ15 RQ20
  wire [7:0] next_lost_sticky = ((lost_sticky & ~clr_lost) | lost_live)
                                & csr_pkg::LOST_IMPL; // RQ16 RQ20
  wire next_irq = |(next_sticky & ~masks); // RQ17 RQ18

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sticky <= csr_pkg::RST_STICKY;
      lost_sticky <= csr_pkg::RST_STICKY;
      irq_o <= 1'b0;
    end else begin
      sticky <= next_sticky;
      lost_sticky <= next_lost_sticky;
      irq_o <= next_irq;
    end
  end

  // ****************************************
  // Core side: writable registers
  // ****************************************
  wire [7:0] next_masks = (do_wr & hit_masks) ? (req.wdata & csr_pkg::STATUS_IMPL) : masks;
  wire [7:0] next_page = (do_wr & hit_page) ? req.wdata : page; // RQ1 RQ2
  wire [4:0] next_addr_hi = (do_wr & hit_addr) ? req.wdata[6:csr_pkg::SLAVE_ADDR_LSB]
                                               : addr_hi; // RQ7

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page <= csr_pkg::RST_PAGE;
      masks <= csr_pkg::RST_MASKS;
      addr_hi <= csr_pkg::RST_SLAVE_ADDR[6:csr_pkg::SLAVE_ADDR_LSB];
    end else begin
      page <= next_page;
      masks <= next_masks;
      addr_hi <= next_addr_hi;
    end
  end

  // Straps are live, so a board change shows without a reset
  assign slave_address_o = {addr_hi, live.strap}; // RQ7

  // ****************************************
  // Core side: read mux and answer
  // ****************************************
  // Identity bytes have no store; only page zero shows them
  wire [7:0] page0_data =
    (req.addr == csr_pkg::OFF_STEPPING) ? {4'h0, STEPPING_CODE} : // RQ3
    (req.addr == csr_pkg::OFF_DIGITS_LO) ? BASE_DIGITS[7:0] : // RQ4
    (req.addr == csr_pkg::OFF_DIGITS_HI) ? BASE_DIGITS[15:8] : // RQ4
    (req.addr == csr_pkg::OFF_SPEED) ? SPEED_CODE : // RQ5
    (req.addr == csr_pkg::OFF_PRODREV) ? PRODREV_CODE : // RQ6
    (req.addr == csr_pkg::OFF_TEMP) ? TEMP_CODE :
    (req.addr == csr_pkg::OFF_PACKAGE) ? PACKAGE_CODE :
    (req.addr == csr_pkg::OFF_SLAVE_ADDR) ? {1'b0, addr_hi, 2'b00} :
    (req.addr == csr_pkg::OFF_LIVE) ? live_status :
    (req.addr == csr_pkg::OFF_LOST_LIVE) ? lost_live :
    (req.addr == csr_pkg::OFF_STICKY) ? sticky :
    (req.addr == csr_pkg::OFF_LOST_STICKY) ? lost_sticky :
    (req.addr == csr_pkg::OFF_MASKS) ? masks : 8'h00;
  wire [7:0] rd_mux = hit_page ? page :
                      hit_ready ? {7'h00, live.ready} : // RQ19
                      on_page0 ? page0_data : 8'h00;

  // Page read returns the page before any write in the same access
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_rdata <= csr_pkg::RST_RDATA;
      ack_tgl <= 1'b0;
    end else begin
      if (req_evt) begin
        core_rdata <= rd_mux;
      end
      ack_tgl <= ack_tgl ^ req_evt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_page_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_evt && req.wr && hit_page) |=> (page == $past(req.wdata))) // RQ1
    else $error("page select did not take the written value");

  a_page_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_evt && hit_page) |=> (core_rdata == $past(page))) // RQ2
    else $error("page select read returned wrong value");

  a_stepping_ro: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_evt && on_page0 && !hit_page && req.addr == csr_pkg::OFF_STEPPING)
    |=> (core_rdata == {4'h0, STEPPING_CODE})) // RQ3
    else $error("stepping code read wrong");

  a_digits_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_evt && on_page0 && req.addr == csr_pkg::OFF_DIGITS_HI)
    |=> (core_rdata == BASE_DIGITS[15:8])) // RQ4
    else $error("base part digits high byte wrong");

  a_addr_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_evt && req.wr && hit_addr) |=> (slave_address_o[6:2] == $past(req.wdata[6:2]))) // RQ7
    else $error("slave address upper bits not written");

  a_sticky_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    live.pll_unlocked |=> sticky[csr_pkg::BIT_LOL]) // RQ15
    else $error("sticky flag missed its live condition");

  a_sticky_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (sticky[csr_pkg::BIT_CAL] && !(do_wr && hit_sticky && !req.wdata[csr_pkg::BIT_CAL]))
    |=> sticky[csr_pkg::BIT_CAL]) // RQ20
    else $error("sticky flag dropped without a clearing write");

  a_lost_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (do_wr && hit_lost && !req.wdata[0] && !live.lost[0])
    |=> (!lost_sticky[0] && lost_sticky[3:1] ==
         $past((lost_sticky[3:1] & req.wdata[3:1]) | live.lost[3:1]))) // RQ16
    else $error("individual lost flag clear wrong");

  a_irq_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ##1 (irq_o == |(sticky & ~$past(masks)))) // RQ18
    else $error("interrupt does not follow unmasked flags");

  a_irq_blocked: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ((sticky & ~masks) == 8'h00 && (live_status & ~masks) == 8'h00
     && !(do_wr && hit_masks)) |=> !irq_o) // RQ17
    else $error("masked flag raised the interrupt");

  a_ready_page: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req_evt && hit_ready) |=> (core_rdata == {7'h00, $past(live.ready)})) // RQ19
    else $error("device ready not readable on this page");

  a_link_answer: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
    (link_req_i && !pend) |=> (pend [*3] ##[1:12] link_done_o))
    else $error("serial access not answered in time");

endmodule

// *** dv/csr_host.sv ***
// Host controller model issuing byte accesses on the link request port
module csr_host (
  input wire logic link_clk_i,
  input wire logic link_busy_i,
  input wire logic link_done_i,
  input wire logic [7:0] link_rdata_i,
  output logic link_req_o,
  output logic link_wr_o,
  output logic [7:0] link_addr_o,
  output logic [7:0] link_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    link_req_o = 1'b0;
    link_wr_o = 1'b0;
    link_addr_o = 8'h00;
    link_wdata_o = 8'h00;
  end

  // One byte access; lines are scrambled once taken so stale values never help
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] r, output logic ok);
    ok = 1'b0;
    r = 8'h00;
    @(negedge link_clk_i);
    link_req_o = 1'b1;
    link_wr_o = w;
    link_addr_o = a;
    link_wdata_o = d;
    @(posedge link_clk_i);
    @(negedge link_clk_i);
    link_req_o = 1'b0;
    link_wr_o = ~w;
    link_addr_o = ~a;
    link_wdata_o = ~d;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge link_clk_i);
      ok = link_done_i;
    end
    r = link_rdata_i;
  endtask

  // Clear chosen sticky flags while writing back the value read for all others
  task automatic clear_flags(input logic [7:0] a, input logic [7:0] clr, output logic ok);
    logic [7:0] r;
    access(1'b0, a, 8'h00, r, ok);
    access(1'b1, a, r & ~clr, r, ok);
  endtask
endmodule

// *** dv/csr_regs_tb.sv ***
// Self-checking testbench for the page-zero register bank
module csr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Identity values are arbitrary, chosen distinct to catch swapped fields
  localparam logic [3:0] STEP = 4'h6;
  localparam logic [15:0] DIGITS = 16'h8642;
  localparam logic [7:0] SPEED = 8'h3C;
  localparam logic [7:0] PREV = 8'h5A;

  logic clk_i, link_clk_i, arst_n_i;
  logic link_req, link_wr, link_busy, link_done, irq, strap_hi, strap_lo, ready;
  logic [7:0] link_addr, link_wdata, link_rdata, stat;
  logic [3:0] lost;
  logic [6:0] slave_addr;
  int miscompares = 0;
  int checks_done = 0;

  csr_regs #(.STEPPING_CODE(STEP), .BASE_DIGITS(DIGITS), .SPEED_CODE(SPEED),
    .PRODREV_CODE(PREV), .TEMP_CODE(8'h11), .PACKAGE_CODE(8'h22)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i),
    .link_req_i(link_req), .link_wr_i(link_wr), .link_addr_i(link_addr),
    .link_wdata_i(link_wdata), .link_busy_o(link_busy), .link_done_o(link_done),
    .link_rdata_o(link_rdata), .calibration_active_i(stat[0]),
    .crystal_signal_lost_i(stat[1]), .reference_missing_i(stat[2]),
    .pll_unlocked_i(stat[3]), .bus_timeout_i(stat[5]), .input_clock_lost_i(lost),
    .address_strap_high_i(strap_hi), .address_strap_low_i(strap_lo),
    .device_ready_i(ready), .slave_address_o(slave_addr), .irq_o(irq));

  csr_host host (.link_clk_i(link_clk_i), .link_busy_i(link_busy),
    .link_done_i(link_done), .link_rdata_i(link_rdata), .link_req_o(link_req),
    .link_wr_o(link_wr), .link_addr_o(link_addr), .link_wdata_o(link_wdata));

  // ****************************************
  // Clocks, unrelated in phase
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #37;
    forever #80 link_clk_i = ~link_clk_i;
  end

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic stop_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // A missing answer ends the run rather than hanging it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    logic ok;
    host.access(w, a, d, r, ok);
    check({7'h00, link_busy}, 8'h00);
    if (!ok) begin
      miscompares++;
      $display("ERROR %0t: no answer from register port", $time);
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    check(r, exp);
  endtask

  // Live levels change on the falling edge, then settle through the syncs
  task automatic set_in(input logic [7:0] s, input logic [3:0] l);
    @(negedge clk_i);
    stat = s;
    lost = l;
    repeat (6) @(negedge clk_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ident();
    wr(csr_pkg::OFF_STEPPING, 8'hFF);
    wr(csr_pkg::OFF_SPEED, 8'hFF);
    rd_chk(csr_pkg::OFF_STEPPING, {4'h0, STEP});
    rd_chk(csr_pkg::OFF_DIGITS_LO, DIGITS[7:0]);
    rd_chk(csr_pkg::OFF_DIGITS_HI, DIGITS[15:8]);
    rd_chk(csr_pkg::OFF_SPEED, SPEED);
    rd_chk(csr_pkg::OFF_PRODREV, PREV);
    rd_chk(8'h06, 8'h00);
    rd_chk(csr_pkg::OFF_MASKS, csr_pkg::RST_MASKS);
  endtask

  task automatic t_page();
    wr(csr_pkg::OFF_PAGE, 8'hA5);
    rd_chk(csr_pkg::OFF_PAGE, 8'hA5);
    rd_chk(csr_pkg::OFF_READY, 8'h01);
    rd_chk(csr_pkg::OFF_STEPPING, 8'h00);
    wr(csr_pkg::OFF_PAGE, 8'hFF);
    rd_chk(csr_pkg::OFF_PAGE, 8'hFF);
    wr(csr_pkg::OFF_PAGE, csr_pkg::PAGE_ZERO);
    rd_chk(csr_pkg::OFF_STEPPING, {4'h0, STEP});
  endtask

  task automatic t_slave();
    wr(csr_pkg::OFF_SLAVE_ADDR, 8'hFF);
    rd_chk(csr_pkg::OFF_SLAVE_ADDR, 8'h7C);
    check({1'b0, slave_addr}, {1'b0, 5'h1F, 2'b10});
    set_in(8'h00, 4'h0);
    strap_hi = 1'b0;
    strap_lo = 1'b1;
    wr(csr_pkg::OFF_SLAVE_ADDR, 8'h54);
    set_in(8'h00, 4'h0);
    check({1'b0, slave_addr}, {1'b0, 5'h15, 2'b01});
  endtask

  // Each status and loss bit alone; flags are left set for the sticky part
  task automatic t_live();
    int pos [5] = '{0, 1, 2, 3, 5};
    foreach (pos[i]) begin
      set_in(8'h01 << pos[i], 4'h0);
      rd_chk(csr_pkg::OFF_LIVE, 8'h01 << pos[i]);
    end
    for (int i = 0; i < 4; i++) begin
      set_in(8'h00, 4'h1 << i);
      rd_chk(csr_pkg::OFF_LOST_LIVE, 8'h01 << i);
    end
    set_in(8'h00, 4'h0);
    rd_chk(csr_pkg::OFF_LOST_LIVE, 8'h00);
    rd_chk(csr_pkg::OFF_LIVE, 8'h00);
  endtask

  task automatic t_sticky();
    logic ok;
    rd_chk(csr_pkg::OFF_STICKY, 8'h2F);
    rd_chk(csr_pkg::OFF_LOST_STICKY, 8'h0F);
    wr(csr_pkg::OFF_STICKY, 8'hFF);
    rd_chk(csr_pkg::OFF_STICKY, 8'h2F);
    host.clear_flags(csr_pkg::OFF_STICKY, 8'h08, ok);
    check({7'h00, ok}, 8'h01);
    rd_chk(csr_pkg::OFF_STICKY, 8'h27);
    host.clear_flags(csr_pkg::OFF_LOST_STICKY, 8'h05, ok);
    check({7'h00, ok}, 8'h01);
    rd_chk(csr_pkg::OFF_LOST_STICKY, 8'h0A);
    set_in(8'h08, 4'h0);
    wr(csr_pkg::OFF_STICKY, 8'h00);
    rd_chk(csr_pkg::OFF_STICKY, 8'h08);
    set_in(8'h00, 4'h0);
    wr(csr_pkg::OFF_STICKY, 8'h00);
    rd_chk(csr_pkg::OFF_STICKY, 8'h00);
  endtask

  task automatic t_irq();
    logic ok;
    set_in(8'h21, 4'h0);
    set_in(8'h00, 4'h0);
    check({7'h00, irq}, 8'h01);
    wr(csr_pkg::OFF_MASKS, 8'h01);
    set_in(8'h00, 4'h0);
    check({7'h00, irq}, 8'h01);
    wr(csr_pkg::OFF_MASKS, 8'h21);
    set_in(8'h00, 4'h0);
    check({7'h00, irq}, 8'h00);
    wr(csr_pkg::OFF_MASKS, 8'hFF);
    rd_chk(csr_pkg::OFF_MASKS, 8'h2F);
    wr(csr_pkg::OFF_MASKS, 8'h00);
    host.clear_flags(csr_pkg::OFF_STICKY, 8'h20, ok);
    check({7'h00, ok}, 8'h01);
    set_in(8'h00, 4'h0);
    check({7'h00, irq}, 8'h01);
    wr(csr_pkg::OFF_STICKY, 8'h00);
    set_in(8'h00, 4'h0);
    check({7'h00, irq}, 8'h00);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    arst_n_i = 1'b0;
    stat = 8'h00;
    lost = 4'h0;
    strap_hi = 1'b1;
    strap_lo = 1'b0;
    ready = 1'b1;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_ident();
    t_page();
    t_slave();
    t_live();
    t_sticky();
    t_irq();
    stop_test();
  end
endmodule
